// ==== rtl/acc_clkdiv.v ====
// Conversion clock enable generator: divides the system clock by divisor+1
`timescale 1ns/100ps
module acc_clkdiv (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Control
  input wire run,
  input wire [4:0] divisor,
  // Output tick, one cycle per conversion clock
  output reg tick
);
  reg [4:0] count; // Cycles since last restart or wrap
  reg [4:0] next_count; // Count after this edge

  // Wrap after the divisor; run low restarts the count from zero
  always @* begin
    if (!run || count >= divisor)
      next_count = 5'h00;
    else
      next_count = count + 5'h01;
  end

  // Tick is raised one cycle early so that the consumer sees it on the
  // edge that closes each whole conversion clock after a restart
  always @(posedge clk) begin
    if (!nrst) begin
      count <= 5'h00;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= (next_count == divisor);
    end
  end
endmodule

// ==== rtl/acc_ctrl.v ====
// Conversion control of a successive-approximation converter
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "acc_regs.vh"
module acc_ctrl #(
  parameter MIN_PERIOD = `ACC_MIN_PERIOD
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Timer overflow pulses and timer width modes
  input wire t0_ovf,
  input wire t1_ovf,
  input wire t2_low_ovf,
  input wire t2_high_ovf,
  input wire t2_split8,
  input wire t3_low_ovf,
  input wire t3_high_ovf,
  input wire t3_split8,
  // External convert strobe pin
  input wire external_convert_strobe,
  // Analog core interface
  input wire [9:0] sar_code,
  output reg core_power,
  output reg core_track,
  output reg core_convert,
  output reg core_diff,
  output reg [4:0] core_pos_sel,
  output reg [4:0] core_neg_sel,
  // Interrupt request
  input wire done_irq_en,
  output reg done_irq
);
  // States of the conversion sequencer
  localparam ST_IDLE = 2'h0;
  localparam ST_TRACK = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_WAITSTB = 2'h3;

  reg converter_on; // Enable bit
  reg left_justify_sel; // Justification bit
  reg low_power_track_sel; // Low-power tracking bit
  reg [2:0] conversion_trigger_sel; // Start source
  reg conversion_active; // Busy bit
  reg conversion_done_flag; // Done flag
  reg [4:0] conv_clock_divisor; // Clock divisor field
  reg [2:0] cfg_spare; // Spare config bits, read back
  reg [4:0] positive_input_select; // Positive input code
  reg [4:0] negative_input_select; // Negative input code
  reg [7:0] result_high_byte; // Result high byte
  reg [7:0] result_low_byte; // Result low byte
  reg [1:0] state; // Sequencer state
  reg [3:0] clk_count; // Conversion clocks in the phase
  reg [15:0] rate_count; // Cycles since last start
  reg busy_q; // Busy delayed, for edge detect
  reg stb_s1; // Strobe synchroniser first stage
  reg stb_s2; // Strobe synchroniser second stage
  reg stb_q; // Strobe delayed, for edge detect
  wire conv_tick; // One pulse per conversion clock
  wire stb_rise; // Rising edge of the synchronised strobe
  wire diff_mode; // Differential mode selected
  wire sw_start; // Software write of one to busy
  reg trig; // Selected start event
  reg [15:0] next_word; // Formatted result
  wire rate_ok; // Minimum spacing since last start met
  wire strobe_lp; // Low-power tracking with the strobe as trigger
  wire start_evt; // A conversion starts at this edge

  // Conversion clock divider, restarted by each start so that tracking
  // and conversion phases last whole conversion clocks
  acc_clkdiv i_acc_clkdiv (
    .clk(clk),
    .nrst(nrst),
    .run(converter_on && !start_evt),
    .divisor(conv_clock_divisor),
    .tick(conv_tick)
  );

  // Two-stage synchroniser and edge detect for the strobe pin
  always @(posedge clk) begin
    if (!nrst) begin
      stb_s1 <= 1'b1;
      stb_s2 <= 1'b1;
      stb_q <= 1'b1;
    end else begin
      stb_s1 <= external_convert_strobe;
      stb_s2 <= stb_s1;
      stb_q <= stb_s2;
    end
  end
  assign stb_rise = stb_s2 & ~stb_q;

  assign diff_mode = (negative_input_select != `ACC_NEG_GND);
  assign sw_start = reg_wr && (reg_addr == `ACC_ADDR_CTRL) &&
    reg_wdata[`ACC_CTRL_BUSY];
  assign rate_ok = (rate_count >= MIN_PERIOD[15:0]);
  assign strobe_lp = low_power_track_sel &&
    (conversion_trigger_sel == `ACC_TRIG_STROBE);
  // Same start conditions as the sequencer below
  assign start_evt = converter_on && rate_ok &&
    ((state == ST_IDLE && !strobe_lp && trig) ||
    (state == ST_WAITSTB && strobe_lp && stb_rise));

  // Start source select; timers 2 and 3 pick byte overflow by width mode
  always @* begin
    case (conversion_trigger_sel)
      `ACC_TRIG_SW: trig = sw_start;
      `ACC_TRIG_T0: trig = t0_ovf;
      `ACC_TRIG_T1: trig = t1_ovf;
      `ACC_TRIG_T2: trig = t2_split8 ? t2_low_ovf : t2_high_ovf;
      `ACC_TRIG_T3: trig = t3_split8 ? t3_low_ovf : t3_high_ovf;
      `ACC_TRIG_STROBE: trig = stb_rise;
      default: trig = 1'b0;
    endcase
  end

  // Result formatting by mode and justification
  always @* begin
    if (!diff_mode) begin
      if (left_justify_sel)
        next_word = {sar_code, 6'h00};
      else
        next_word = {6'h00, sar_code};
    end else begin
      if (left_justify_sel)
        next_word = {sar_code, 6'h00};
      else
        next_word = {{6{sar_code[9]}}, sar_code};
    end
  end

  // Register writes, sequencer and flags
  always @(posedge clk) begin
    if (!nrst) begin
      converter_on <= 1'b0;
      left_justify_sel <= 1'b0;
      low_power_track_sel <= 1'b0;
      conversion_trigger_sel <= `ACC_TRIG_SW;
      conversion_active <= 1'b0;
      conversion_done_flag <= 1'b0;
      conv_clock_divisor <= 5'h1f;
      cfg_spare <= 3'h0;
      positive_input_select <= `ACC_POS_RST;
      negative_input_select <= `ACC_NEG_RST;
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
      state <= ST_IDLE;
      clk_count <= 4'h0;
      rate_count <= 16'hffff;
      busy_q <= 1'b0;
      done_irq <= 1'b0;
    end else begin
      busy_q <= conversion_active;
      if (rate_count != 16'hffff)
        rate_count <= rate_count + 16'h0001;
      // Software writes
      if (reg_wr) begin
        case (reg_addr)
          `ACC_ADDR_CTRL: begin
            converter_on <= reg_wdata[`ACC_CTRL_ON];
            low_power_track_sel <= reg_wdata[`ACC_CTRL_TRACK];
            conversion_trigger_sel <=
              reg_wdata[`ACC_CTRL_TRIG_HI:`ACC_CTRL_TRIG_LO];
            left_justify_sel <= reg_wdata[`ACC_CTRL_LJST];
            // Software may clear the done flag; a set below wins
            if (!reg_wdata[`ACC_CTRL_DONE])
              conversion_done_flag <= 1'b0;
          end
          `ACC_ADDR_CFG: begin
            conv_clock_divisor <=
              reg_wdata[`ACC_CFG_DIV_HI:`ACC_CFG_DIV_LO];
            cfg_spare <= reg_wdata[2:0];
          end
          `ACC_ADDR_POS: positive_input_select <= reg_wdata[4:0];
          `ACC_ADDR_NEG: negative_input_select <= reg_wdata[4:0];
          default: ;
        endcase
      end
      // Sequencer
      if (!converter_on) begin
        state <= ST_IDLE;
        conversion_active <= 1'b0;
        clk_count <= 4'h0;
      end else begin
        case (state)
          ST_IDLE: begin
            clk_count <= 4'h0;
            if (low_power_track_sel &&
                conversion_trigger_sel == `ACC_TRIG_STROBE) begin
              if (!stb_s2)
                state <= ST_WAITSTB;
            end else if (trig && rate_ok) begin
              conversion_active <= 1'b1;
              rate_count <= 16'h0000;
              state <= low_power_track_sel ? ST_TRACK : ST_CONV;
            end
          end
          ST_WAITSTB: begin
            // Tracks while strobe low, converts on its rising edge
            if (!low_power_track_sel ||
                conversion_trigger_sel != `ACC_TRIG_STROBE)
              state <= ST_IDLE;
            else if (stb_rise && rate_ok) begin
              conversion_active <= 1'b1;
              rate_count <= 16'h0000;
              clk_count <= 4'h0;
              state <= ST_CONV;
            end
          end
          ST_TRACK: begin
            if (conv_tick) begin
              if (clk_count == `ACC_TRACK_CLKS - 4'h1) begin
                clk_count <= 4'h0;
                state <= ST_CONV;
              end else
                clk_count <= clk_count + 4'h1;
            end
          end
          ST_CONV: begin
            if (conv_tick) begin
              if (clk_count == `ACC_CONV_CLKS - 4'h1) begin
                clk_count <= 4'h0;
                conversion_active <= 1'b0;
                state <= ST_IDLE;
                result_high_byte <= next_word[15:8];
                result_low_byte <= next_word[7:0];
              end else
                clk_count <= clk_count + 4'h1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
      // Falling edge of busy sets the done flag; set beats clear
      if (busy_q && !conversion_active)
        conversion_done_flag <= 1'b1;
      done_irq <= busy_q && !conversion_active && done_irq_en;
    end
  end

  // Read data, one cycle after the read strobe
  always @(posedge clk) begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `ACC_ADDR_CTRL: reg_rdata <= {converter_on, low_power_track_sel,
          conversion_active, conversion_done_flag,
          conversion_trigger_sel, left_justify_sel};
        `ACC_ADDR_CFG: reg_rdata <= {conv_clock_divisor, cfg_spare};
        `ACC_ADDR_POS: reg_rdata <= {3'h0, positive_input_select};
        `ACC_ADDR_NEG: reg_rdata <= {3'h0, negative_input_select};
        `ACC_ADDR_RES_HI: reg_rdata <= result_high_byte;
        `ACC_ADDR_RES_LO: reg_rdata <= result_low_byte;
        default: reg_rdata <= 8'h00;
      endcase
    end else
      reg_rdata <= 8'h00;
  end

  // Analog core controls
  always @(posedge clk) begin
    if (!nrst) begin
      core_power <= 1'b0;
      core_track <= 1'b0;
      core_convert <= 1'b0;
      core_diff <= 1'b0;
      core_pos_sel <= 5'h00;
      core_neg_sel <= 5'h00;
    end else begin
      core_power <= converter_on;
      core_convert <= converter_on && state == ST_CONV;
      if (!converter_on)
        core_track <= 1'b0;
      else if (!low_power_track_sel)
        core_track <= (state != ST_CONV);
      else
        core_track <= (state == ST_TRACK) || (state == ST_WAITSTB);
      core_diff <= diff_mode;
      core_pos_sel <= positive_input_select;
      core_neg_sel <= negative_input_select;
    end
  end
endmodule

// ==== rtl/acc_regs.vh ====
// Register offsets, fields, reset values and timing counts of the converter
`ifndef ACC_REGS_VH
`define ACC_REGS_VH
// Register indices on the plain register port
`define ACC_ADDR_CTRL 3'h0
`define ACC_ADDR_CFG 3'h1
`define ACC_ADDR_POS 3'h2
`define ACC_ADDR_NEG 3'h3
`define ACC_ADDR_RES_HI 3'h4
`define ACC_ADDR_RES_LO 3'h5
// Control register fields
`define ACC_CTRL_LJST 0
`define ACC_CTRL_TRIG_LO 1
`define ACC_CTRL_TRIG_HI 3
`define ACC_CTRL_DONE 4
`define ACC_CTRL_BUSY 5
`define ACC_CTRL_TRACK 6
`define ACC_CTRL_ON 7
// Config register fields
`define ACC_CFG_DIV_LO 3
`define ACC_CFG_DIV_HI 7
// Reset values
`define ACC_CTRL_RST 8'h00
`define ACC_CFG_RST 8'hf8
`define ACC_POS_RST 5'h00
`define ACC_NEG_RST 5'h00
// Trigger encodings
`define ACC_TRIG_SW 3'h0
`define ACC_TRIG_T0 3'h1
`define ACC_TRIG_T2 3'h2
`define ACC_TRIG_T1 3'h3
`define ACC_TRIG_STROBE 3'h4
`define ACC_TRIG_T3 3'h5
// Negative input code meaning ground
`define ACC_NEG_GND 5'h1f
// Conversion timing in conversion clocks
`define ACC_TRACK_CLKS 4'h3
`define ACC_CONV_CLKS 4'hb
// Fastest conversion rate in samples per second and the period in cycles
`define ACC_CLK_HZ 100000000
`define ACC_MAX_SPS 200000
`define ACC_MIN_PERIOD (`ACC_CLK_HZ / `ACC_MAX_SPS)
`endif

// ==== tb/acc_ctrl_checker.sv ====
// Port assertions for the converter control block
`timescale 1ns/100ps
module acc_ctrl_checker #(
  parameter MIN_PERIOD = 500
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register port
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Core side and interrupt
  input wire core_power,
  input wire core_track,
  input wire core_convert,
  input wire core_diff,
  input wire [4:0] core_neg_sel,
  input wire done_irq_en,
  input wire done_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Cycles since the last conversion rose, saturating
  reg [15:0] gap;
  reg conv_d;
  always @(posedge clk) begin
    conv_d <= core_convert;
    if (!nrst)
      gap <= 16'hffff;
    else if (core_convert && !conv_d)
      gap <= 16'h0001;
    else if (gap != 16'hffff)
      gap <= gap + 16'h0001;
  end
  a_off_idle: assert property (!core_power |-> !core_convert)
    else $error("converting while off");
  a_diff_mode: assert property ($past(nrst) |->
    core_diff == (core_neg_sel != 5'h1f)) else $error("bad mode");
  a_track_excl: assert property (core_convert |-> !core_track)
    else $error("tracking while converting");
  a_conv_len: assert property ($rose(core_convert) |->
    core_convert[*8]) else $error("conversion too short");
  a_irq_after: assert property ($fell(core_convert) && done_irq_en
    |-> ##[0:2] done_irq) else $error("no done request");
  a_irq_single: assert property (done_irq |=> !done_irq)
    else $error("request too long");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  a_unmapped_rd: assert property (reg_rd && reg_addr > 3'h5 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_power_off: assert property (reg_wr && reg_addr == 3'h0 &&
    !reg_wdata[7] |-> ##2 !core_power) else $error("still powered");
  a_rate_limit: assert property ($rose(core_convert) |->
    gap + 16'd96 >= MIN_PERIOD) else $error("rate too high");
endmodule
bind acc_ctrl acc_ctrl_checker #(.MIN_PERIOD(MIN_PERIOD)) i_acc_ctrl_checker (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_power(core_power), .core_track(core_track),
  .core_convert(core_convert), .core_diff(core_diff),
  .core_neg_sel(core_neg_sel), .done_irq_en(done_irq_en),
  .done_irq(done_irq));

// ==== tb/acc_ctrl_test.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/100ps
module acc_ctrl_test;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [9:0] sar_code = 10'h000;
  reg done_irq_en = 1'b1;
  wire [7:0] reg_rdata;
  wire [5:0] ovf;
  wire [1:0] split8;
  wire [4:0] pos, neg;
  wire strobe, pwr, track, conv, diff, done_irq;
  integer num_errors = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer irqs = 0;
  integer i, k, n_tr, n_cv;
  reg [7:0] rv;
  reg [27:0] fv;
  reg [9:0] tv;
  always #5 clk = ~clk;
  acc_trig_model i_acc_trig_model (.clk(clk), .ovf(ovf), .split8(split8),
    .strobe(strobe));
  acc_ctrl #(.MIN_PERIOD(20)) i_acc_ctrl (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .t0_ovf(ovf[0]),
    .t1_ovf(ovf[1]), .t2_low_ovf(ovf[2]), .t2_high_ovf(ovf[3]),
    .t2_split8(split8[0]), .t3_low_ovf(ovf[4]), .t3_high_ovf(ovf[5]),
    .t3_split8(split8[1]), .external_convert_strobe(strobe),
    .sar_code(sar_code), .core_power(pwr), .core_track(track),
    .core_convert(conv), .core_diff(diff), .core_pos_sel(pos),
    .core_neg_sel(neg), .done_irq_en(done_irq_en), .done_irq(done_irq));
  // Count requests and cut a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (done_irq === 1'b1)
      irqs = irqs + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  // Read data is taken in the cycle after the strobe
  task rd(input [2:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge clk);
    end
  endtask
  // Poll the done flag, then expect done set and busy clear
  task wait_done;
    begin
      rv = 8'h00;
      for (k = 0; k < 100 && rv[4] !== 1'b1; k = k + 1)
        rd(3'h0);
      chk(rv & 8'h30, 8'h10);
    end
  endtask
  // Start by software and count tracking and converting cycles
  task measure(input [7:0] c);
    begin
      n_tr = 0;
      n_cv = 0;
      reg_addr <= 3'h0;
      reg_wdata <= c;
      reg_wr <= 1'b1;
      for (k = 0; k < 200; k = k + 1) begin
        @(posedge clk);
        reg_wr <= 1'b0;
        #1 n_cv = n_cv + (conv === 1'b1);
        n_tr = n_tr + (track === 1'b1 && conv !== 1'b1);
      end
      @(posedge clk);
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 8; i = i + 1) begin
      rd(i[2:0]);
      chk(rv, i == 1 ? 8'hf8 : 8'h00);
    end
    wr(3'h2, 8'hfe);
    rd(3'h2);
    chk(rv, 8'h1e);
    chk({3'h0, pos}, 8'h1e);
    wr(3'h0, 8'h20);
    rd(3'h0);
    chk(rv, 8'h00);
    chk({7'h0, pwr}, 8'h00);
    // Code formats in both modes and justifications
    wr(3'h1, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      case (i)
        0: fv = {2'b00, 10'h3ff, 16'h03ff};
        1: fv = {2'b01, 10'h3ff, 16'hffc0};
        2: fv = {2'b10, 10'h1ff, 16'h01ff};
        3: fv = {2'b10, 10'h200, 16'hfe00};
        4: fv = {2'b11, 10'h1ff, 16'h7fc0};
        default: fv = {2'b11, 10'h200, 16'h8000};
      endcase
      sar_code <= fv[25:16];
      wr(3'h3, fv[27] ? 8'h00 : 8'h1f);
      wr(3'h0, 8'h80);
      repeat (16) @(posedge clk);
      chk({7'h0, pwr}, 8'h01);
      chk({7'h0, diff}, {7'h0, fv[27]});
      chk({3'h0, neg}, fv[27] ? 8'h00 : 8'h1f);
      wr(3'h0, {7'h50, fv[26]});
      wait_done;
      rd(3'h4);
      chk(rv, fv[15:8]);
      rd(3'h5);
      chk(rv, fv[7:0]);
    end
    // Each timer and strobe trigger source: a decoy is ignored, the chosen one starts
    wr(3'h1, 8'h18);
    for (i = 0; i < 7; i = i + 1) begin
      case (i)
        0: tv = {3'h1, 3'h0, 3'h1, 1'b0};
        1: tv = {3'h3, 3'h1, 3'h0, 1'b0};
        2: tv = {3'h2, 3'h2, 3'h3, 1'b1};
        3: tv = {3'h2, 3'h3, 3'h2, 1'b0};
        4: tv = {3'h5, 3'h4, 3'h5, 1'b1};
        5: tv = {3'h5, 3'h5, 3'h4, 1'b0};
        default: tv = {3'h4, 3'h6, 3'h0, 1'b0};
      endcase
      wr(3'h0, {4'h8, tv[9:7], 1'b0});
      i_acc_trig_model.fire(tv[3:1], tv[0]);
      rd(3'h0);
      chk(rv & 8'h20, 8'h00);
      i_acc_trig_model.fire(tv[6:4], tv[0]);
      rd(3'h0);
      chk(rv & 8'h20, 8'h20);
      wait_done;
    end
    chk(irqs[7:0], 8'h0d);
    // Tracking and conversion lengths with the request masked
    done_irq_en <= 1'b0;
    wr(3'h1, 8'h08);
    wr(3'h0, 8'hc0);
    measure(8'he0);
    chk(n_tr[7:0], 8'h06);
    chk(n_cv[7:0], 8'h16);
    wr(3'h1, 8'h10);
    wr(3'h0, 8'h80);
    measure(8'ha0);
    chk(n_cv[7:0], 8'h21);
    chk({7'h0, track}, 8'h01);
    // A start within the minimum spacing is refused, a later one runs
    wr(3'h1, 8'h00);
    wr(3'h0, 8'ha0);
    repeat (11) @(posedge clk);
    wr(3'h0, 8'ha0);
    rd(3'h0);
    chk(rv & 8'h20, 8'h00);
    repeat (8) @(posedge clk);
    wr(3'h0, 8'ha0);
    rd(3'h0);
    chk(rv & 8'h20, 8'h20);
    wait_done;
    chk(irqs[7:0], 8'h0d);
    finish_test;
  end
endmodule

// ==== tb/acc_trig_model.sv ====
// Timer overflow and convert strobe source model
`timescale 1ns/100ps
module acc_trig_model (
  // Clock
  input wire clk,
  // Overflows: t0, t1, t2 low/high, t3 low/high
  output reg [5:0] ovf,
  // Timer 2/3 eight-bit modes, strobe pin
  output reg [1:0] split8,
  output reg strobe
);
  initial begin
    ovf = 6'h00;
    split8 = 2'h0;
    strobe = 1'b0;
  end
  // One overflow pulse, or a strobe rise held nine cycles
  task fire(input [2:0] s, input sp);
    begin
      split8 <= {sp, sp};
      @(posedge clk);
      if (s == 3'h6)
        strobe <= 1'b1;
      else
        ovf <= 6'h01 << s;
      @(posedge clk);
      ovf <= 6'h00;
      repeat (8) @(posedge clk);
      strobe <= 1'b0;
    end
  endtask
endmodule
